// ===== hdl/asramc_ctrl.sv
`timescale 1ns/1ps
`include "asramc_cfg.svh"

// Notes on behaviour
// R1: 32768 words of 16 bits, 15-bit address
// R2: write only while select and strobe low
// R3: byte selects gate each stored byte
// R4: read: select low, gate low, strobe high
// R5: byte selects gate each driven byte
// R6: memory floats bus when not reading
// R7: write window is overlap of three lows
// R8: assert select, strobe, byte select together
// R9: time data to the write-ending edge
// R10: wait 100 us before first access
// R11: read cycle at least access time
// R12: read data held 3 ns after change
// R13: data valid after select falls
// R14: data valid after gate falls
// R15: address stable before window closes
// R16: address stable at window start
// R17: address held until window closed
// R18: write data 6 ns before ending edge
// R19: byte select low before write ends
// R20: simultaneous rise keeps outputs floating
// R21: address valid by select falling edge
// R22: deselect before retention supply
// R23: never drive bus while memory may drive
module asramc_ctrl (
    input wire logic CLK_I, // clock, 100 MHz
    input wire logic NRST_I, // async reset, low
    input wire logic REQ_VALID_I, // request present
    input wire asramc_pkg::asramc_req_t REQ_I, // request fields
    output logic REQ_READY_O, // request taken
    output logic RD_VALID_O, // read data pulse
    output logic [`ASRAMC_DATA_W-1:0] RD_DATA_O, // read data
    input wire logic RETAIN_I, // retention requested
    output logic RETAIN_OK_O, // memory deselected
    output logic [`ASRAMC_ADDR_W-1:0] MEM_ADDR_O, // address pins
    output asramc_pkg::asramc_ctl_t MEM_CTL_O, // control pins
    input wire logic [`ASRAMC_DATA_W-1:0] MEM_DQ_I, // data in
    output logic [`ASRAMC_DATA_W-1:0] MEM_DQ_O, // data out
    output logic MEM_DQ_OE_O // data drive enable
);
    import asramc_pkg::*;

    asramc_state_t state_q, state_d;
    asramc_ctl_t ctl_q; // registered pins
    logic [`ASRAMC_ADDR_W-1:0] addr_q; // registered address
    logic [`ASRAMC_DATA_W-1:0] wdata_q; // registered write data
    logic [`ASRAMC_DATA_W-1:0] rdata_q; // captured read data
    logic rvalid_q; // read pulse
    logic oe_q; // bus drive enable
    logic ready_q; // first cycle after reset passed, wait armed
    logic tmr_load; // timer load
    logic [`ASRAMC_CNT_W-1:0] tmr_val; // timer load value
    logic tmr_zero; // timer expired
    logic take; // request taken

    // cycle counts sized for the counter
    function automatic logic [`ASRAMC_CNT_W-1:0] cyc(input int n);
        cyc = n[`ASRAMC_CNT_W-1:0];
    endfunction

    asramc_timer u_tmr (
        .CLK_I(CLK_I),
        .NRST_I(NRST_I),
        .load_i(tmr_load),
        .val_i(tmr_val),
        .zero_o(tmr_zero)
    );

    // requests accepted only idle, powered and not retaining
    assign take = (state_q == ST_IDLE) && REQ_VALID_I && !RETAIN_I;
    assign REQ_READY_O = take;

    // next state and timer loads
    always_comb begin
        state_d = state_q;
        tmr_load = 1'b0;
        tmr_val = '0;
        unique case (state_q)
            ST_POWER: begin
                // first cycle out of reset arms the long wait; the
                // timer is wide enough for the whole count
                if (!ready_q) begin
                    tmr_load = 1'b1;
                    tmr_val = cyc(`ASRAMC_PWR_CYC); // R10
                end else if (tmr_zero) begin
                    state_d = ST_IDLE; // R10
                end
            end
            ST_IDLE: begin
                if (take) begin
                    tmr_load = 1'b1;
                    if (REQ_I.wr) begin
                        state_d = ST_WRITE;
                        tmr_val = cyc(`ASRAMC_WR_CYC); // R19
                    end else begin
                        state_d = ST_READ;
                        tmr_val = cyc(`ASRAMC_RD_CYC); // R11
                    end
                end
            end
            ST_READ: begin
                if (tmr_zero) begin
                    state_d = ST_TURN;
                    tmr_load = 1'b1;
                    tmr_val = cyc(`ASRAMC_HIZ_CYC); // R23
                end
            end
            ST_WRITE: begin
                if (tmr_zero) begin
                    state_d = ST_TURN;
                    tmr_load = 1'b1;
                    tmr_val = cyc(`ASRAMC_HIZ_CYC);
                end
            end
            ST_TURN: begin
                if (tmr_zero) begin
                    state_d = ST_IDLE;
                end
            end
        endcase
    end

    // state register
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            state_q <= ST_POWER;
        end else begin
            state_q <= state_d;
        end
    end

    // power-up wait: timer loaded once after reset release
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ready_q <= 1'b0;
        end else begin
            ready_q <= 1'b1;
        end
    end

    // address and data latch at request time, held through turn
    // so address is stable through the window and after it
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            addr_q <= '0;
            wdata_q <= '0;
        end else if (take) begin
            addr_q <= REQ_I.addr; // R15 R16 R17 R21
            wdata_q <= REQ_I.wdata; // R18
        end
    end

    // control pins; all edges of a window come together with the
    // address, a zero setup the memory accepts; the window branch sets
    // lane selects only on entry, so no passing all-high value shows mid-window
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            ctl_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                       low_byte_sel_n: 1'b1, high_byte_sel_n: 1'b1};
        end else if (state_d == ST_READ || state_d == ST_WRITE) begin
            ctl_q.cs_n <= 1'b0; // R2 R4 R8
            ctl_q.we_n <= (state_d != ST_WRITE); // R2 R8
            ctl_q.oe_n <= (state_d != ST_READ); // R4 R23
            // lane selects taken once, held through the window
            if (state_q == ST_IDLE) begin
                ctl_q.low_byte_sel_n <= !REQ_I.be[0]; // R3
                ctl_q.high_byte_sel_n <= !REQ_I.be[1]; // R3
            end
        end else begin
            ctl_q <= '{cs_n: 1'b1, we_n: 1'b1, oe_n: 1'b1,
                       low_byte_sel_n: 1'b1, high_byte_sel_n: 1'b1};
        end
    end

    // bus drive only during write; gate is high then (R23)
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            oe_q <= 1'b0;
        end else begin
            oe_q <= (state_d == ST_WRITE); // R9 R23
        end
    end

    // capture read data at last cycle of the access
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            rdata_q <= '0;
            rvalid_q <= 1'b0;
        end else begin
            rvalid_q <= (state_q == ST_READ) && tmr_zero; // R11
            if ((state_q == ST_READ) && tmr_zero) begin
                rdata_q <= MEM_DQ_I;
            end
        end
    end

    assign MEM_ADDR_O = addr_q;
    assign MEM_CTL_O = ctl_q;
    assign MEM_DQ_O = wdata_q;
    assign MEM_DQ_OE_O = oe_q;
    assign RD_DATA_O = rdata_q;
    assign RD_VALID_O = rvalid_q;
    // deselected whenever idle or waiting (R22)
    assign RETAIN_OK_O = RETAIN_I && ctl_q.cs_n &&
                         (state_q == ST_IDLE || state_q == ST_POWER);

    // never drive the bus with the gate low
    chk_drive_gate: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        MEM_DQ_OE_O |-> MEM_CTL_O.oe_n) // R23
        else $error("bus driven while gate low");
    // write strobe only with select
    chk_write_sel: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !MEM_CTL_O.we_n |-> !MEM_CTL_O.cs_n && MEM_DQ_OE_O) // R2
        else $error("strobe without select");
    // read pins: strobe high
    chk_read_pins: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !MEM_CTL_O.oe_n |-> MEM_CTL_O.we_n && !MEM_CTL_O.cs_n) // R4
        else $error("bad read pins");
    // no access before power wait
    chk_power_wait: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        state_q == ST_POWER |-> MEM_CTL_O.cs_n) // R10
        else $error("access during power wait");
    // address stable while selected
    chk_addr_hold: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        !MEM_CTL_O.cs_n && !$past(MEM_CTL_O.cs_n) |-> $stable(MEM_ADDR_O))
        else $error("address moved in window"); // R17
    // write pulse lasts its full length
    sequence s_wr_start;
        $fell(MEM_CTL_O.we_n);
    endsequence
    chk_wr_width: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        s_wr_start |-> !MEM_CTL_O.we_n [*2]) // R19
        else $error("write pulse short");
    // read data pulse follows a read window
    chk_rd_pulse: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        RD_VALID_O |-> $past(!MEM_CTL_O.oe_n)) // R11
        else $error("read pulse without window");
    // retention only when deselected
    chk_retain: assert property (@(posedge CLK_I) disable iff (!NRST_I)
        RETAIN_OK_O |-> MEM_CTL_O.cs_n) // R22
        else $error("retention while selected");
endmodule // asramc_ctrl

// ===== pkg/asramc_cfg.svh
`ifndef ASRAMC_CFG_SVH
`define ASRAMC_CFG_SVH

// memory geometry
`define ASRAMC_ADDR_W 15
`define ASRAMC_DATA_W 16
`define ASRAMC_DEPTH 32768
// clock period in ns
`define ASRAMC_CLK_NS 10
// timing figures in ns (slower grade covers both)
`define ASRAMC_T_ACCESS_NS 12
`define ASRAMC_T_WPULSE_NS 8
`define ASRAMC_T_DSETUP_NS 6
`define ASRAMC_T_HIZ_NS 6
// power-up wait in us
`define ASRAMC_T_POWER_US 100
// derived cycle counts: least times round up
`define ASRAMC_RD_CYC \
    ((`ASRAMC_T_ACCESS_NS + `ASRAMC_CLK_NS - 1) / `ASRAMC_CLK_NS)
`define ASRAMC_WR_CYC \
    ((`ASRAMC_T_WPULSE_NS + `ASRAMC_CLK_NS - 1) / `ASRAMC_CLK_NS)
`define ASRAMC_HIZ_CYC \
    ((`ASRAMC_T_HIZ_NS + `ASRAMC_CLK_NS - 1) / `ASRAMC_CLK_NS)
`define ASRAMC_PWR_CYC \
    ((`ASRAMC_T_POWER_US * 1000 + `ASRAMC_CLK_NS - 1) / `ASRAMC_CLK_NS)
// counter width
`define ASRAMC_CNT_W 14

`endif

// ===== pkg/asramc_pkg.sv
`include "asramc_cfg.svh"

package asramc_pkg;
    // request from the user side
    typedef struct packed {
        logic wr;
        logic [1:0] be;
        logic [`ASRAMC_ADDR_W-1:0] addr;
        logic [`ASRAMC_DATA_W-1:0] wdata;
    } asramc_req_t;

    // memory control pins, all active low
    typedef struct packed {
        logic cs_n;
        logic we_n;
        logic oe_n;
        logic low_byte_sel_n; // lower lane select
        logic high_byte_sel_n; // upper lane select
    } asramc_ctl_t;

    typedef enum logic [2:0] {
        ST_POWER, ST_IDLE, ST_READ, ST_WRITE, ST_TURN
    } asramc_state_t;
endpackage

// ===== hdl/asramc_timer.sv
`timescale 1ns/1ps
`include "asramc_cfg.svh"

// down counter: loads a count, flags zero
module asramc_timer (
    input wire logic CLK_I, // clock
    input wire logic NRST_I, // async reset, low
    input wire logic load_i, // load strobe
    input wire logic [`ASRAMC_CNT_W-1:0] val_i, // load value
    output logic zero_o // count reached zero
);
    logic [`ASRAMC_CNT_W-1:0] cnt_q;

    // loads win over counting
    always_ff @(posedge CLK_I or negedge NRST_I) begin
        if (!NRST_I) begin
            cnt_q <= '0;
        end else if (load_i) begin
            cnt_q <= val_i;
        end else if (cnt_q != '0) begin
            cnt_q <= cnt_q - 1'b1;
        end
    end

    assign zero_o = (cnt_q == '0);
endmodule // asramc_timer

// ===== sim/asramc_sram_model.sv
`timescale 1ns/1ps
`include "asramc_cfg.svh"

// behavioural static memory standing on the far side of the pins
module asramc_sram_model (
    input wire logic [14:0] addr_i, // address pins
    input wire asramc_pkg::asramc_ctl_t ctl_i, // control pins
    input wire logic [15:0] hdq_i, // controller data
    input wire logic hoe_i, // controller drives bus
    output logic [15:0] dq_o, // resolved bus level
    output logic bad_o // controller broke a pin rule
);
    import asramc_pkg::*;
    logic [15:0] mem [0:`ASRAMC_DEPTH-1];
    logic [15:0] acc, last, d1, d6;
    logic [14:0] a1, a8;
    logic [1:0] ln;
    logic wwin, rd, clash;
    asramc_ctl_t c1;
    // delayed copies show what the pins held just before an edge
    assign #1 a1 = addr_i;
    assign #8 a8 = addr_i;
    assign #1 d1 = hdq_i;
    assign #6 d6 = hdq_i;
    assign #1 c1 = ctl_i;
    assign ln = {ctl_i.high_byte_sel_n, ctl_i.low_byte_sel_n};
    // write window: overlap of select, strobe and a byte select
    assign wwin = !ctl_i.cs_n && !ctl_i.we_n && !(&ln);
    assign rd = !ctl_i.cs_n && !ctl_i.oe_n && ctl_i.we_n;
    // data lags the address by the access time
    assign #12 acc = mem[addr_i];
    assign #1 clash = hoe_i && rd && !(&ln);
    initial begin
        bad_o = 1'b0;
        last = 16'h0000;
        for (int i = 0; i < `ASRAMC_DEPTH; i++) mem[i] = 16'h0000;
    end
    // store at the closing edge, using values from just before it
    always @(negedge wwin) begin
        if (a8 !== a1 || d6 !== d1) bad_o = 1'b1;
        if (!c1.low_byte_sel_n) mem[a1][7:0] = d1[7:0];
        if (!c1.high_byte_sel_n) mem[a1][15:8] = d1[15:8];
    end
    // both parties driving at once would burn the pins
    always @(posedge clash) bad_o = 1'b1;
    // undriven byte shows the inverse of its last level, no pull
    always @* begin
        for (int b = 0; b < 2; b++) begin
            if (hoe_i) dq_o[b*8+:8] = hdq_i[b*8+:8];
            else if (rd && !ln[b]) dq_o[b*8+:8] = acc[b*8+:8];
            else dq_o[b*8+:8] = ~last[b*8+:8];
            if (hoe_i || (rd && !ln[b])) last[b*8+:8] = dq_o[b*8+:8];
        end
    end
endmodule // asramc_sram_model

// ===== sim/asramc_tb_top.sv
`timescale 1ns/1ps
`include "asramc_cfg.svh"

module asramc_tb_top;
    import asramc_pkg::*;
    logic clk, nrst, vld, rdy, rv, ret, rok, doe, bad;
    asramc_req_t req;
    asramc_ctl_t mc;
    logic [15:0] rdat, dqi, dqo, d;
    logic [14:0] ma, a;
    logic [1:0] be;
    logic [15:0] ref_mem [0:32767]; // expected contents
    int error_cnt, compares, cyc, seed, waited, n;

    asramc_ctrl dut (.CLK_I(clk), .NRST_I(nrst), .REQ_VALID_I(vld),
        .REQ_I(req), .REQ_READY_O(rdy), .RD_VALID_O(rv),
        .RD_DATA_O(rdat), .RETAIN_I(ret), .RETAIN_OK_O(rok),
        .MEM_ADDR_O(ma), .MEM_CTL_O(mc), .MEM_DQ_I(dqi),
        .MEM_DQ_O(dqo), .MEM_DQ_OE_O(doe));
    asramc_sram_model mem_m (.addr_i(ma), .ctl_i(mc), .hdq_i(dqo),
        .hoe_i(doe), .dq_o(dqi), .bad_o(bad));

    // free running clock
    initial begin
        clk = 1'b0;
        forever #5 clk = ~clk;
    end

    // closing report
    task give_verdict;
        $display("compares %0d mismatches %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask

    task chk(input logic [15:0] got, input logic [15:0] exp,
             input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: %s", $time, m);
        end
    endtask

    // one request, entered at a falling edge; reads compare lanes only
    task op(input logic w, input logic [1:0] b, input logic [14:0] ad,
            input logic [15:0] wd);
        logic [15:0] m;
        m = {{8{b[1]}}, {8{b[0]}}};
        vld = 1'b1;
        req = '{wr: w, be: b, addr: ad, wdata: wd};
        waited = 0;
        while (rdy !== 1'b1 && waited < 20000) begin
            @(negedge clk);
            waited++;
        end
        @(negedge clk);
        vld = 1'b0;
        if (w) ref_mem[ad] = (ref_mem[ad] & ~m) | (wd & m);
        else begin
            n = 1;
            while (rv !== 1'b1 && n < 10) begin
                @(negedge clk);
                n++;
            end
            chk(16'(n), 16'd4, "read answer late");
            chk(rdat & m, ref_mem[ad] & m, "read data");
        end
    endtask

    // hang guard
    always @(posedge clk) begin
        cyc++;
        if (cyc == 40000) begin
            error_cnt++;
            $display("wrong value at %0t: timeout", $time);
            give_verdict;
        end
    end

    initial begin
        seed = 74650;
        nrst = 1'b0;
        vld = 1'b0;
        ret = 1'b0;
        req = '0;
        error_cnt = 0;
        compares = 0;
        cyc = 0;
        for (int i = 0; i < 32768; i++) ref_mem[i] = 16'h0000;
        repeat (20) @(negedge clk);
        nrst = 1'b1;
        op(1'b0, 2'b11, 15'h0000, 16'h0000);
        chk(16'(waited >= `ASRAMC_PWR_CYC), 16'd1, "early access");
        $display("test power wait done");
        // every lane mix, upper lane alone at 0000, the other two at 7FFF
        for (int b = 1; b < 4; b++) begin
            d = 16'($random(seed));
            a = (b == 2) ? 15'h0000 : 15'h7FFF;
            op(1'b1, 2'b11, a, ~d);
            op(1'b1, b[1:0], a, d);
            for (int r = 1; r < 4; r++) op(1'b0, r[1:0], a, d);
        end
        $display("test byte lanes done");
        // random back-to-back traffic on a small address set
        repeat (80) begin
            a = 15'($random(seed)) & 15'h000F;
            be = 2'($random(seed));
            if (be == 2'b00) be = 2'b11;
            op(1'($random(seed)), be, a, 16'($random(seed)));
        end
        $display("test random traffic done");
        // retention request blocks access and deselects
        ret = 1'b1;
        vld = 1'b1;
        req = '0;
        n = 0;
        while (rok !== 1'b1 && n < 20) begin
            @(negedge clk);
            n++;
        end
        chk(16'(rok), 16'd1, "retention not granted");
        repeat (5) begin
            @(negedge clk);
            chk(16'(mc.cs_n), 16'd1, "selected in retention");
            chk(16'(rdy), 16'd0, "taken in retention");
        end
        vld = 1'b0;
        ret = 1'b0;
        @(negedge clk);
        op(1'b0, 2'b11, 15'h7FFF, 16'h0000);
        $display("test retention done");
        chk(16'(bad), 16'd0, "pin timing or bus clash");
        give_verdict;
    end
endmodule // asramc_tb_top
